// ---- bench/block_io_input_and_cond_jump_tb.sv ----
// self-checking bench for the block input / jump unit
`timescale 1ns/1ps
module block_io_input_and_cond_jump_tb
  import ioj_pkg::*;
;
  // bench drives
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  // unit and model outputs
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, io_rd, mem_wr;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [31:0] s_rdata, last_wr, v;
  logic [23:0] io_addr, mem_addr;
  logic [7:0] io_rdata, mem_wdata;
  logic t;
  int errors = 0, checks_done = 0;
  ioj_exec_unit ioj_exec_unit_inst (.*);
  ioj_io_mem_model ioj_io_mem_model_inst (.*);
  // 100 MHz core clock
  always #5 core_clk = ~core_clk;
  // counts, verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // a wait that ran out ends the run
  task automatic guard(input logic ok);
    if (ok !== 1'b1)
    begin
      errors++;
      report_and_stop();
    end
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // axi4-lite write; each channel held until its own ready
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    repeat (40)
    begin
      @(posedge core_clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    guard(s_bvalid);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask
  // axi4-lite read
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge core_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    // rready follows rvalid a cycle late so the slave must hold its data
    repeat (40)
    begin
      @(posedge core_clk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && s_rready) break;
      if (s_rvalid) s_rready <= 1'b1;
    end
    guard(s_rvalid && s_rready);
    d = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  // start one instruction and poll until it is no longer busy
  task automatic go(input logic [31:0] insn);
    wr(OFF_INSN, insn);
    wr(OFF_CTRL, 32'h1);
    v = 32'h1;
    for (int n = 0; n < 100 && v[ST_BUSY] !== 1'b0; n++)
      rd(OFF_CTRL, v);
    guard(v[ST_BUSY] === 1'b0);
  endtask
  task automatic inp(input logic [31:0] insn, bc, de, cyc, ebc, ede, ehl,
    efl, ewr);
    wr(OFF_BC, bc);
    wr(OFF_DE, de);
    go(insn);
    rc(OFF_CYCLES, cyc);
    rc(OFF_BC, ebc);
    rc(OFF_DE, ede);
    rc(OFF_HL, ehl);
    rc(OFF_FLAGS, efl);
    chk(last_wr, ewr);
  endtask
  task automatic jmp(input logic [31:0] insn, op, cyc, st, epc, emd);
    wr(OFF_OPER, op);
    go(insn);
    rc(OFF_CTRL, st);
    rc(OFF_CYCLES, cyc);
    rc(OFF_PC, epc);
    rc(OFF_MODE, emd);
  endtask
  // preset flags keep s, h, p/v and c set to show they are untouched
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    wr(OFF_FLAGS, 32'h95);
    wr(OFF_HL, 32'h1000);
    inp(32'h00b2ed00, 32'h01ab, 32'h0, 32'h5, 32'h00ab, 32'h0, 32'h1001,
      32'hd5, 32'h3c001000);
    inp(32'h00c2ed00, 32'h2, 32'h1280, 32'h8, 32'h0, 32'h1280, 32'h1003,
      32'hd5, 32'h04001002);
    inp(32'h0094ed00, 32'h2, 32'h1280, 32'h8, 32'h0, 32'h1282, 32'h1005,
      32'hd5, 32'h05001004);
    inp(32'h0082ed00, 32'h0305, 32'h0, 32'h5, 32'h0206, 32'h0, 32'h1006,
      32'h97, 32'h93001005);
    inp(32'h0092ed52, 32'h0206, 32'h0, 32'h9, 32'h0008, 32'h0, 32'h1008,
      32'hd7, 32'h91001007);
    wr(OFF_HL, 32'h56ffff);
    inp(32'h00b2ed49, 32'h01ab, 32'h0, 32'h6, 32'h00ab, 32'h0, 32'h570000,
      32'hd5, 32'h3c56ffff);
    for (int f = 0; f < 2; f++)
    begin
      wr(OFF_FLAGS, f ? 32'hc5 : 32'h0);
      for (int i = 0; i < 8; i++)
      begin
        t = i[0] ^ (f == 0);
        jmp({16'h0, 2'b11, i[2:0], 3'b010, 8'h0}, 32'h2468, 32'h3 + 32'(t),
          t ? 32'ha : 32'h2, 32'h2468, 32'h0);
      end
    end
    jmp(32'hca5b, 32'h123456, 32'h6, 32'ha, 32'h123456, 32'h1);
    jmp(32'hca00, 32'h654321, 32'h5, 32'ha, 32'h654321, 32'h1);
    jmp(32'hca40, 32'h00abcd, 32'h5, 32'ha, 32'h65abcd, 32'h0);
    wr(OFF_MODE, 32'h3c00);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    jmp(32'hca00, 32'h771357, 32'h4, 32'ha, 32'h651357, 32'h3c00);
    rc(OFF_FETCH, 32'h3c1357);
    go(32'hca52);
    rc(OFF_CTRL, 32'h6);
    rd(12'h02c, v);
    chk({30'h0, rsp}, {30'h0, RESP_DECERR});
    wr(12'h030, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_DECERR});
    report_and_stop();
  end
endmodule

// ---- bench/ioj_exec_unit_properties.sv ----
// assertion checker on the input / jump unit pins
`timescale 1ns/1ps
module ioj_exec_unit_properties
  import ioj_pkg::*;
(
  // clock, reset and read channel
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  // far side pins
  input wire logic [23:0] io_addr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // peripherals may not decode the top byte, so it is kept quiet
  AST_IO_TOP: assert property (io_rd |-> io_addr[23:16] == 8'h00)
    else $error("io top byte set");
  AST_MEM_NEXT: assert property (
    io_rd |=> mem_wr && mem_wdata == $past(io_rdata))
    else $error("bad write after read");
  AST_MEM_CAUSE: assert property (mem_wr |-> $past(io_rd))
    else $error("write without read");
  AST_PASS_GAP: assert property (io_rd |=> !io_rd [*2])
    else $error("passes too close");
  AST_AR_ANS: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read not answered");
  AST_R_HOLD: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  AST_R_DONE: assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("read held after take");
  AST_R_ERR: assert property (
    s_rvalid && s_rresp == RESP_DECERR |-> s_rdata == 32'h0)
    else $error("error read with data");
  // main scenarios
  cover property (io_rd ##3 io_rd);
  cover property (mem_wr);
  cover property (s_rvalid && s_rresp == RESP_DECERR);
endmodule
bind ioj_exec_unit ioj_exec_unit_properties
  ioj_exec_unit_properties_inst (.*);

// ---- bench/ioj_io_mem_model.sv ----
// far side model: one i/o peripheral and the byte memory
`timescale 1ns/1ps
module ioj_io_mem_model (
  // unit pins
  input wire logic core_clk,
  input wire logic [23:0] io_addr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr,
  // last byte and address written
  output logic [31:0] last_wr
);
  assign io_rdata = io_addr[7:0] ^ io_addr[15:8] ^ 8'h96 ^ {8{!io_rd}};
  always @(posedge core_clk)
    if (mem_wr)
      last_wr <= {mem_wdata, mem_addr};
endmodule

// ---- hdl/ioj_axil_slave.sv ----
// axi4-lite slave front end for the unit registers
`timescale 1ns/1ps
module ioj_axil_slave
  import ioj_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // axi4-lite
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // register port
  ioj_regs_if.slv rb
);
  // read data is picked combinationally from the live address
  assign rb.rd_addr = s_araddr;

  // write path: address and data taken in either order
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      rb.wr_en <= 1'b0;
      rb.wr_addr <= 12'h000;
      rb.wr_data <= 32'h0000_0000;
      rb.wr_strb <= 4'h0;
    end
    else
    begin
      rb.wr_en <= 1'b0;
      if (s_awvalid && s_awready)
      begin
        rb.wr_addr <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        rb.wr_data <= s_wdata;
        rb.wr_strb <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (!s_awready && !s_wready && !s_bvalid)
      begin
        rb.wr_en <= ioj_mapped(rb.wr_addr);
        s_bresp <= ioj_mapped(rb.wr_addr) ? RESP_OKAY : RESP_DECERR;
        s_bvalid <= 1'b1;
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // read path: one cycle from address to data
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rdata <= rb.rd_data;
      s_rresp <= ioj_mapped(s_araddr) ? RESP_OKAY : RESP_DECERR;
      s_rvalid <= 1'b1;
      s_arready <= 1'b0;
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end
endmodule

// ---- hdl/ioj_decoder.sv ----
// instruction and suffix decoder
`timescale 1ns/1ps
module ioj_decoder
  import ioj_pkg::*;
(
  // decode request and result
  ioj_dec_if.dec d
);
  logic is_in;
  logic is_jp;

  // opcode class, width and legality
  always_comb
  begin
    d.kind = K_NONE;
    d.cond_sel = d.op0[5:3];
    is_jp = (d.op0 & OP_JP_MASK) == OP_JP_MATCH;
    is_in = d.op0 == OP_EXT;
    if (is_in)
    begin
      case (d.op1)
        OP_C_STEP: d.kind = K_C_STEP;
        OP_C_REP: d.kind = K_C_REP;
        OP_PAIR_REP: d.kind = K_PAIR_REP;
        OP_FIXED_REP: d.kind = K_FIXED_REP;
        OP_STEP_REP: d.kind = K_STEP_REP;
        default: d.kind = K_NONE;
      endcase
    end
    else if (is_jp)
      d.kind = K_JUMP;
    d.prefixed = d.prefix != PFX_NONE;
    d.long_data = d.wide_mode;
    d.illegal = d.kind == K_NONE;
    if (d.kind == K_JUMP)
    begin
      if (d.prefix == PFX_JP_SHORT) d.long_data = 1'b0;
      else if (d.prefix == PFX_JP_LONG) d.long_data = 1'b1;
      else if (d.prefixed) d.illegal = 1'b1;
    end
    else if (d.prefix == PFX_SHORT) d.long_data = 1'b0;
    else if (d.prefix == PFX_LONG) d.long_data = 1'b1;
    else if (d.prefixed) d.illegal = 1'b1;
  end
endmodule

// ---- hdl/ioj_exec_unit.sv ----
// block input and conditional jump execution unit
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module ioj_exec_unit
  import ioj_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // axi4-lite register bus
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // i/o read port
  output logic [23:0] io_addr,
  output logic io_rd,
  input wire logic [7:0] io_rdata,
  // memory write port
  output logic [23:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_wr
);
  // ************************************************************
  // state
  // ************************************************************
  ioj_state_t state_reg;
  logic [2:0] cnt_reg;
  logic [19:0] cyc_reg;
  logic [15:0] bc_reg;
  logic [15:0] de_reg;
  logic [23:0] hl_reg;
  logic [23:0] pc_reg;
  logic [7:0] flags_reg;
  logic wide_reg;
  logic [7:0] base_reg;
  logic [23:0] insn_reg;
  logic [23:0] oper_reg;
  logic [7:0] data_reg;
  logic done_reg;
  logic illegal_reg;
  logic taken_reg;
  logic [31:0] wr_word;
  logic idle;
  logic sw_wr;
  logic start;
  logic again;
  logic finish;
  logic jump_end;
  logic cond_true;
  logic [2:0] jp_total;
  logic [2:0] pre_total;
  logic [7:0] b_dec;
  logic [15:0] bc_dec;

  ioj_regs_if rb ();
  ioj_dec_if dec ();

  // ************************************************************
  // helpers
  // ************************************************************
  // full address: 24-bit pointer in wide mode, else page plus 16 bits
  function automatic logic [23:0] ext_ptr(input logic wide,
                                          input logic [7:0] page,
                                          input logic [23:0] ptr);
    return wide ? ptr : {page, ptr[15:0]};
  endfunction

  // pointer step keeps the upper byte when only 16 bits are live
  function automatic logic [23:0] ptr_inc(input logic wide,
                                          input logic [23:0] ptr);
    logic [23:0] sum;
    sum = ptr + 24'h000001;
    return wide ? sum : {ptr[23:16], sum[15:0]};
  endfunction

  function automatic logic cond_eval(input logic [7:0] f,
                                     input logic [2:0] sel);
    logic flag;
    case (sel[2:1])
      2'b00: flag = f[FLAG_Z];
      2'b01: flag = f[FLAG_C];
      2'b10: flag = f[FLAG_PV];
      default: flag = f[FLAG_S];
    endcase
    return sel[0] ? flag : ~flag;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    return res;
  endfunction

  // register read view, shared by the bus and the byte-lane merge
  function automatic logic [31:0] read_word(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFF_CTRL:
      begin
        v[ST_BUSY] = state_reg != S_IDLE;
        v[ST_DONE] = done_reg;
        v[ST_ILLEGAL] = illegal_reg;
        v[ST_TAKEN] = taken_reg;
      end
      OFF_INSN: v[23:0] = insn_reg;
      OFF_OPER: v[23:0] = oper_reg;
      OFF_BC: v[15:0] = bc_reg;
      OFF_DE: v[15:0] = de_reg;
      OFF_HL: v[23:0] = hl_reg;
      OFF_PC: v[23:0] = pc_reg;
      OFF_FLAGS: v[7:0] = flags_reg;
      OFF_MODE:
      begin
        v[MODE_WIDE] = wide_reg;
        v[MODE_BASE_LSB +: 8] = base_reg;
      end
      OFF_CYCLES: v[19:0] = cyc_reg;
      OFF_FETCH: v[23:0] = ext_ptr(wide_reg, base_reg, pc_reg);
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ************************************************************
  // bus slave and decoder
  // ************************************************************
  ioj_axil_slave ioj_axil_slave_inst (
    .core_clk (core_clk),
    .reset_n (reset_n),
    .s_awaddr (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata (s_wdata),
    .s_wstrb (s_wstrb),
    .s_wvalid (s_wvalid),
    .s_wready (s_wready),
    .s_bresp (s_bresp),
    .s_bvalid (s_bvalid),
    .s_bready (s_bready),
    .s_araddr (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata (s_rdata),
    .s_rresp (s_rresp),
    .s_rvalid (s_rvalid),
    .s_rready (s_rready),
    .rb (rb)
  );

  ioj_decoder ioj_decoder_inst (
    .d (dec)
  );

  // instruction word: prefix in byte 0, opcode bytes above it
  assign dec.prefix = insn_reg[7:0];
  assign dec.op0 = insn_reg[15:8];
  assign dec.op1 = insn_reg[23:16];
  assign dec.wide_mode = wide_reg;

  // a process, not an assign: the view must follow every register it reads
  always_comb
  begin
    rb.rd_data = read_word(rb.rd_addr);
  end

  // ************************************************************
  // control decisions
  // ************************************************************
  always_comb
  begin
    idle = state_reg == S_IDLE;
    // software may only retarget the unit while it is idle
    sw_wr = rb.wr_en && idle;
    wr_word = merge(read_word(rb.wr_addr), rb.wr_data, rb.wr_strb);
    start = sw_wr && rb.wr_addr == OFF_CTRL && rb.wr_strb[0] &&
            rb.wr_data[CTRL_START];
    b_dec = bc_reg[15:8] - 8'h01;
    bc_dec = bc_reg - 16'h0001;
    cond_true = cond_eval(flags_reg, dec.cond_sel);
    jp_total = (dec.long_data ? CYC_JP_LONG : CYC_JP_SHORT) +
               {2'b00, dec.prefixed} + {2'b00, cond_true};
    // overhead ahead of the first pass
    pre_total = CYC_IN_PRE + {2'b00, dec.prefixed};
    // loop while the count stays nonzero
    case (dec.kind)
      K_C_REP, K_PAIR_REP: again = b_dec != 8'h00;
      K_FIXED_REP, K_STEP_REP: again = bc_dec != 16'h0000;
      default: again = 1'b0;
    endcase
    jump_end = state_reg == S_JUMP && cnt_reg == 3'h0;
    finish = (state_reg == S_STEP && !again) || jump_end;
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  // each pass is read, write, update: three cycles
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= 3'h0;
      cyc_reg <= 20'h00000;
    end
    else
    begin
      if (!idle)
        cyc_reg <= cyc_reg + 20'h00001;
      case (state_reg)
        S_IDLE:
          if (start && !dec.illegal)
          begin
            cyc_reg <= 20'h00000;
            // untaken jump drops the extra cycle
            if (dec.kind == K_JUMP)
            begin
              state_reg <= S_JUMP;
              cnt_reg <= jp_total - 3'h1;
            end
            else
            begin
              state_reg <= S_PRE;
              cnt_reg <= pre_total - 3'h1;
            end
          end
        S_PRE:
          if (cnt_reg == 3'h0) state_reg <= S_IORD;
          else cnt_reg <= cnt_reg - 3'h1;
        S_IORD: state_reg <= S_MEMWR;
        S_MEMWR: state_reg <= S_STEP;
        S_STEP: state_reg <= again ? S_IORD : S_IDLE;
        S_JUMP:
          if (cnt_reg == 3'h0) state_reg <= S_IDLE;
          else cnt_reg <= cnt_reg - 3'h1;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // bus pins
  // ************************************************************
  // strobes are one-cycle pulses; data is sampled at the end of io_rd
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      io_addr <= 24'h000000;
      io_rd <= 1'b0;
      mem_addr <= 24'h000000;
      mem_wdata <= 8'h00;
      mem_wr <= 1'b0;
      data_reg <= 8'h00;
    end
    else
    begin
      io_rd <= 1'b0;
      mem_wr <= 1'b0;
      if (state_reg == S_IORD)
      begin
        io_rd <= 1'b1;
        // upper byte is don't-care; held at zero here
        case (dec.kind)
          // c on low byte, zero above
          K_C_STEP, K_C_REP: io_addr <= {16'h0000, bc_reg[7:0]};
          K_PAIR_REP: io_addr <= {8'h00, bc_reg};
          default: io_addr <= {8'h00, de_reg};
        endcase
      end
      // byte goes to memory at hl after the read
      if (state_reg == S_MEMWR)
      begin
        data_reg <= io_rdata;
        mem_wdata <= io_rdata;
        mem_addr <= ext_ptr(dec.long_data, base_reg, hl_reg);
        mem_wr <= 1'b1;
      end
    end
  end

  // ************************************************************
  // architectural registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bc_reg <= 16'h0000;
      de_reg <= 16'h0000;
      hl_reg <= 24'h000000;
      pc_reg <= 24'h000000;
      flags_reg <= RST_FLAGS;
      wide_reg <= RST_WIDE;
      base_reg <= RST_BASE_PAGE;
      insn_reg <= 24'h000000;
      oper_reg <= 24'h000000;
    end
    else if (sw_wr)
    begin
      case (rb.wr_addr)
        OFF_INSN: insn_reg <= wr_word[23:0];
        OFF_OPER: oper_reg <= wr_word[23:0];
        OFF_BC: bc_reg <= wr_word[15:0];
        OFF_DE: de_reg <= wr_word[15:0];
        OFF_HL: hl_reg <= wr_word[23:0];
        OFF_PC: pc_reg <= wr_word[23:0];
        OFF_FLAGS: flags_reg <= wr_word[7:0];
        OFF_MODE:
        begin
          wide_reg <= wr_word[MODE_WIDE];
          base_reg <= wr_word[MODE_BASE_LSB +: 8];
        end
        default: wide_reg <= wide_reg;
      endcase
    end
    else if (state_reg == S_STEP)
    begin
      hl_reg <= ptr_inc(dec.long_data, hl_reg);
      // subtract flag mirrors data bit 7
      flags_reg[FLAG_N] <= data_reg[7];
      case (dec.kind)
        // b down, c up, zero from new b
        K_C_STEP, K_C_REP:
        begin
          bc_reg <= {b_dec, bc_reg[7:0] + 8'h01};
          flags_reg[FLAG_Z] <= b_dec == 8'h00;
        end
        K_PAIR_REP:
        begin
          bc_reg[15:8] <= b_dec;
          flags_reg[FLAG_Z] <= b_dec == 8'h00;
        end
        K_FIXED_REP:
        begin
          bc_reg <= bc_dec;
          flags_reg[FLAG_Z] <= bc_dec == 16'h0000;
        end
        K_STEP_REP:
        begin
          bc_reg <= bc_dec;
          de_reg <= de_reg + 16'h0001;
          flags_reg[FLAG_Z] <= bc_dec == 16'h0000;
        end
        default: bc_reg <= bc_reg;
      endcase
    end
    else if (jump_end && cond_true)
    begin
      if (dec.long_data)
      begin
        pc_reg <= oper_reg;
        wide_reg <= 1'b1;
      end
      else
      begin
        // low 16 bits, wide mode off
        pc_reg[15:0] <= oper_reg[15:0];
        wide_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // status
  // ************************************************************
  // a legal start clears the old outcome, an illegal one sets done and illegal; completion sets it again
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      taken_reg <= 1'b0;
    end
    else if (start)
    begin
      done_reg <= dec.illegal;
      illegal_reg <= dec.illegal;
      taken_reg <= 1'b0;
    end
    else if (finish)
    begin
      done_reg <= 1'b1;
      taken_reg <= jump_end && cond_true;
    end
  end
endmodule

// ---- hdl/ioj_ifs.sv ----
// carriers between the unit core, its decoder and its bus slave
`timescale 1ns/1ps
interface ioj_regs_if;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
               input rd_data);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output rd_data);
endinterface

interface ioj_dec_if;
  import ioj_pkg::*;
  logic [7:0] prefix;
  logic [7:0] op0;
  logic [7:0] op1;
  logic wide_mode;
  ioj_kind_t kind;
  logic long_data;
  logic prefixed;
  logic illegal;
  logic [2:0] cond_sel;
  modport dec (input prefix, op0, op1, wide_mode,
               output kind, long_data, prefixed, illegal, cond_sel);
  modport core (output prefix, op0, op1, wide_mode,
                input kind, long_data, prefixed, illegal, cond_sel);
endinterface

// ---- hdl/ioj_pkg.sv ----
// constants, types and helpers shared by the block input / jump unit
package ioj_pkg;
  // ************************************************************
  // instruction encodings
  // ************************************************************
  localparam logic [7:0] OP_EXT = 8'hed;
  localparam logic [7:0] OP_C_STEP = 8'h82;
  localparam logic [7:0] OP_C_REP = 8'h92;
  localparam logic [7:0] OP_PAIR_REP = 8'hb2;
  localparam logic [7:0] OP_FIXED_REP = 8'hc2;
  localparam logic [7:0] OP_STEP_REP = 8'h94;
  localparam logic [7:0] OP_JP_MASK = 8'hc7;
  localparam logic [7:0] OP_JP_MATCH = 8'hc2;
  localparam logic [7:0] PFX_NONE = 8'h00;
  localparam logic [7:0] PFX_SHORT = 8'h52;
  localparam logic [7:0] PFX_LONG = 8'h49;
  localparam logic [7:0] PFX_JP_SHORT = 8'h40;
  localparam logic [7:0] PFX_JP_LONG = 8'h5b;
  // ************************************************************
  // register map and field positions
  // ************************************************************
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_INSN = 12'h004;
  localparam logic [11:0] OFF_OPER = 12'h008;
  localparam logic [11:0] OFF_BC = 12'h00c;
  localparam logic [11:0] OFF_DE = 12'h010;
  localparam logic [11:0] OFF_HL = 12'h014;
  localparam logic [11:0] OFF_PC = 12'h018;
  localparam logic [11:0] OFF_FLAGS = 12'h01c;
  localparam logic [11:0] OFF_MODE = 12'h020;
  localparam logic [11:0] OFF_CYCLES = 12'h024;
  localparam logic [11:0] OFF_FETCH = 12'h028;
  localparam int CTRL_START = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_TAKEN = 3;
  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N = 1;
  localparam int FLAG_C = 0;
  localparam int MODE_WIDE = 0;
  localparam int MODE_BASE_LSB = 8;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_BASE_PAGE = 8'h00;
  localparam logic RST_WIDE = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  // ************************************************************
  // timing in core clock cycles
  // ************************************************************
  localparam logic [2:0] CYC_IN_PRE = 3'h2;
  localparam logic [2:0] CYC_JP_SHORT = 3'h3;
  localparam logic [2:0] CYC_JP_LONG = 3'h4;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    K_NONE = 3'b000, K_C_STEP = 3'b001, K_C_REP = 3'b010,
    K_PAIR_REP = 3'b011, K_FIXED_REP = 3'b100, K_STEP_REP = 3'b101,
    K_JUMP = 3'b110
  } ioj_kind_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_PRE = 3'b001, S_IORD = 3'b010,
    S_MEMWR = 3'b011, S_STEP = 3'b100, S_JUMP = 3'b101
  } ioj_state_t;
  // word aligned and inside the map
  function automatic logic ioj_mapped(input logic [11:0] a);
    return (a[1:0] == 2'b00) && (a <= OFF_FETCH);
  endfunction
endpackage
